// file: common/eps_store_map.vh
// constants and map of the encoder parameter store
// What this block does
// R1: profile version word: minor in bits 0-7, major in 8-15, decimal, upper bits zero.
// R2: profile version reads the same whether compatibility mode is on or off.
// R3: keep power-on time in whole hours as an unsigned 32-bit parameter.
// R4: write the hour count into non-volatile storage every six minutes while powered.
// R5: hour function unused: hour parameter reads all ones.
// R6: preset computes the offset; reported position is shifted by that offset.
// R7: offset kept in non-volatile storage and returned on every read.
// R8: offset is signed, 32-bit for ranges up to 32 bits, else 64-bit.
// R9: preset acts on the scaled position, so offset is in scaled units.
// R10: offset parameters are read-only; writes leave them unchanged.
// R11: parameter 925 is unsigned 16-bit, readable and writable.
// R12: parameter 971 is write-only; a write stores the parameter set.
// R13: parameter 980 is a read-only list of all supported parameter numbers.
// R14: identification arrays, telegram selection and profile number are read-only.
// R15: station parameters 61000-61004 are read-only name, IP, MAC, gateway, mask.
// R16: preset readable and writable as signed 32-bit (65000) or 64-bit (65002).
// R17: a preset saved by 971 is reloaded from non-volatile storage at startup.
// R18: operating status arrays 65001 (32-bit) and 65003 (64-bit) are read-only.
// R19: hour counter steps by one after each full hour of power-on time.
// R20: write to read-only or read of write-only gives an error, no change.
`ifndef EPS_STORE_MAP_VH
`define EPS_STORE_MAP_VH

// timing
`define EPS_CLK_HZ 40'h0002625A00
`define EPS_HOUR_S 40'h0000000E10
`define EPS_SAVE_S 40'h0000000168
`define EPS_HOUR_CYC (`EPS_HOUR_S * `EPS_CLK_HZ)
`define EPS_SAVE_CYC (`EPS_SAVE_S * `EPS_CLK_HZ)

// parameter numbers
`define EPS_PN_TELSEL 16'h039A
`define EPS_PN_SOLTOL 16'h039D
`define EPS_PN_DEVID 16'h03C4
`define EPS_PN_PROFNUM 16'h03C5
`define EPS_PN_STORE 16'h03CB
`define EPS_PN_ACCID 16'h03CE
`define EPS_PN_OBJID 16'h03CF
`define EPS_PN_SENSFMT 16'h03D3
`define EPS_PN_LIST 16'h03D4
`define EPS_PN_STNAME 16'hEE48
`define EPS_PN_STIP 16'hEE49
`define EPS_PN_STMAC 16'hEE4A
`define EPS_PN_STGW 16'hEE4B
`define EPS_PN_STMASK 16'hEE4C
`define EPS_PN_PRE32 16'hFDE8
`define EPS_PN_OPST32 16'hFDE9
`define EPS_PN_PRE64 16'hFDEA
`define EPS_PN_OPST64 16'hFDEB
`define EPS_LIST_LEN 8'h12

// access kinds
`define EPS_ACC_NONE 2'h0
`define EPS_ACC_RO 2'h1
`define EPS_ACC_RW 2'h2
`define EPS_ACC_WO 2'h3

// values
`define EPS_PROF_MINOR 8'h01
`define EPS_PROF_MAJOR 8'h04
`define EPS_VER_RSVD 16'h0000
`define EPS_SOLTOL_RST 16'h0001
`define EPS_HOURS_UNUSED 32'hFFFFFFFF
`define EPS_NAME_LEN 8'hF0
`define EPS_OPST_VER 8'h06
`define EPS_OPST_HRS 8'h07
`define EPS_OPST_OFS 8'h08
`define EPS_OPST64_OFS 8'h01
`define EPS_MAC_OCTETS 8'h06
`define EPS_ZERO64 64'h0000000000000000

`endif

// file: core/eps_store.v
// parameter store of a networked absolute rotary encoder
`include "eps_store_map.vh"

module eps_store #(
	parameter [39:0] HOUR_CYCLES = `EPS_HOUR_CYC,
	parameter [39:0] SAVE_CYCLES = `EPS_SAVE_CYC,
	parameter [15:0] TELEGRAM = 16'h0051,
	parameter [15:0] PROFILE_NUMBER = 16'h3D00,
	// identification values are arbitrary
	parameter [15:0] VENDOR_CODE = 16'h1234,
	parameter [15:0] DEVICE_CODE = 16'h5678,
	parameter [15:0] ACCESS_INFO = 16'h00F0,
	parameter [15:0] OBJECT_INFO = 16'h0001,
	parameter [31:0] SENSOR_FORMAT = 32'h00000000
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// parameter request
	input wire reqValid,
	input wire reqWrite,
	input wire [15:0] reqNumber,
	input wire [7:0] reqIndex,
	input wire [63:0] reqData,
	// parameter response
	output reg rspValid_q,
	output reg rspError_q,
	output reg [63:0] rspData_q,
	// startup values from non-volatile storage
	input wire nvHoursUsed,
	input wire [31:0] nvHours,
	input wire [63:0] nvOffset,
	input wire nvPresetStored,
	input wire [63:0] nvPreset,
	// writes to non-volatile storage
	output reg nvHoursWr_q,
	output reg [31:0] nvHoursData_q,
	output reg nvParamWr_q,
	output reg [63:0] nvOffsetData_q,
	output reg [63:0] nvPresetData_q,
	output reg nvPresetFlag_q,
	// position path
	input wire wideRange,
	input wire compatMode,
	input wire presetCmd,
	input wire [63:0] scaledPos,
	output reg [63:0] shiftedPos_q,
	output reg ready_q,
	// station data
	input wire nameWrEn,
	input wire [7:0] nameWrIdx,
	input wire [7:0] nameWrByte,
	input wire [31:0] stationIp,
	input wire [47:0] stationMac,
	input wire [31:0] stationGw,
	input wire [31:0] stationMask
);

	localparam S_LOAD = 1'b0;
	localparam S_RUN = 1'b1;

	reg state_q;
	reg hoursUsed_q;
	reg [31:0] hours_q;
	reg [39:0] hourTick_q;
	reg [39:0] saveTick_q;
	reg [63:0] offset_q;
	reg [63:0] preset_q;
	reg presetSaved_q;
	reg [15:0] solTol_q;
	reg [7:0] stationName [0:239];

	// access right of each parameter number
	function [1:0] accessOf;
		input [15:0] num;
		begin
			if (num == `EPS_PN_SOLTOL || num == `EPS_PN_PRE32 || num == `EPS_PN_PRE64) begin
				accessOf = `EPS_ACC_RW; // [R11] [R16]
			end else if (num == `EPS_PN_STORE) begin
				accessOf = `EPS_ACC_WO; // [R12]
			end else if (num == `EPS_PN_TELSEL || num == `EPS_PN_DEVID || num == `EPS_PN_PROFNUM ||
				num == `EPS_PN_ACCID || num == `EPS_PN_OBJID || num == `EPS_PN_SENSFMT) begin
				accessOf = `EPS_ACC_RO; // [R14]
			end else if (num == `EPS_PN_LIST) begin
				accessOf = `EPS_ACC_RO; // [R13]
			end else if (num >= `EPS_PN_STNAME && num <= `EPS_PN_STMASK) begin
				accessOf = `EPS_ACC_RO; // [R15]
			end else if (num == `EPS_PN_OPST32 || num == `EPS_PN_OPST64) begin
				accessOf = `EPS_ACC_RO; // [R18] [R10]
			end else begin
				accessOf = `EPS_ACC_NONE;
			end
		end
	endfunction

	// entry of the supported-parameter list
	function [15:0] listEntry;
		input [7:0] idx;
		begin
			case (idx)
				8'h00: listEntry = `EPS_PN_TELSEL;
				8'h01: listEntry = `EPS_PN_SOLTOL;
				8'h02: listEntry = `EPS_PN_DEVID;
				8'h03: listEntry = `EPS_PN_PROFNUM;
				8'h04: listEntry = `EPS_PN_STORE;
				8'h05: listEntry = `EPS_PN_ACCID;
				8'h06: listEntry = `EPS_PN_OBJID;
				8'h07: listEntry = `EPS_PN_SENSFMT;
				8'h08: listEntry = `EPS_PN_LIST;
				8'h09: listEntry = `EPS_PN_STNAME;
				8'h0A: listEntry = `EPS_PN_STIP;
				8'h0B: listEntry = `EPS_PN_STMAC;
				8'h0C: listEntry = `EPS_PN_STGW;
				8'h0D: listEntry = `EPS_PN_STMASK;
				8'h0E: listEntry = `EPS_PN_PRE32;
				8'h0F: listEntry = `EPS_PN_OPST32;
				8'h10: listEntry = `EPS_PN_PRE64;
				8'h11: listEntry = `EPS_PN_OPST64;
				default: listEntry = 16'h0000;
			endcase
		end
	endfunction

	// wraps a 32-bit difference the way a narrow range counts
	function [31:0] preset32Diff;
		input [31:0] a;
		input [31:0] b;
		begin
			preset32Diff = a - b;
		end
	endfunction

	// sign extension of the 32-bit parameter forms
	function [63:0] sext32;
		input [31:0] v;
		begin
			sext32 = {{32{v[31]}}, v};
		end
	endfunction

	// derived values
	wire [31:0] versionWord;
	wire [31:0] hoursView;
	wire [31:0] offset32View;
	wire [31:0] preset32View;
	wire [63:0] newOffset;
	wire [63:0] posSum;
	wire [31:0] diff32;
	wire hoursAtTop;
	wire hourDone;
	wire saveDone;
	wire [1:0] reqAccess;
	wire reqBad;

	// compatibility mode deliberately not used here
	assign versionWord = {`EPS_VER_RSVD, `EPS_PROF_MAJOR, `EPS_PROF_MINOR}; // [R1] [R2]
	assign hoursView = hoursUsed_q ? hours_q : `EPS_HOURS_UNUSED; // [R5] [R3]
	// wide ranges show zero in the 32-bit forms
	assign offset32View = wideRange ? 32'h00000000 : offset_q[31:0]; // [R8]
	assign preset32View = wideRange ? 32'h00000000 : preset_q[31:0];
	// offset taken on the scaled position, not raw steps
	// narrow ranges wrap the difference at 32 bits before sign extension
	assign diff32 = preset32Diff(preset_q[31:0], scaledPos[31:0]); // [R8]
	assign newOffset = wideRange ? (preset_q - scaledPos) : sext32(diff32); // [R6] [R9] [R8]
	assign posSum = scaledPos + offset_q; // [R6]
	assign hourDone = hourTick_q == (HOUR_CYCLES - 40'h0000000001); // [R19]
	assign saveDone = saveTick_q == (SAVE_CYCLES - 40'h0000000001); // [R4]
	assign hoursAtTop = hours_q == (`EPS_HOURS_UNUSED - 32'h00000001);
	assign reqAccess = accessOf(reqNumber);
	assign reqBad = (reqAccess == `EPS_ACC_NONE) ||
		(reqWrite && reqAccess == `EPS_ACC_RO) ||
		(!reqWrite && reqAccess == `EPS_ACC_WO) || (state_q == S_LOAD); // [R20] [R10] [R12]

	// read data mux
	reg [63:0] readData;
	always @* begin
		readData = `EPS_ZERO64;
		if (reqNumber == `EPS_PN_TELSEL) begin
			readData = {48'h000000000000, TELEGRAM};
		end else if (reqNumber == `EPS_PN_SOLTOL) begin
			readData = {48'h000000000000, solTol_q}; // [R11]
		end else if (reqNumber == `EPS_PN_DEVID) begin
			readData = {48'h000000000000, (reqIndex == 8'h00) ? VENDOR_CODE : DEVICE_CODE}; // [R14]
		end else if (reqNumber == `EPS_PN_PROFNUM) begin
			readData = {48'h000000000000, PROFILE_NUMBER};
		end else if (reqNumber == `EPS_PN_ACCID) begin
			readData = {48'h000000000000, ACCESS_INFO};
		end else if (reqNumber == `EPS_PN_OBJID) begin
			readData = {48'h000000000000, OBJECT_INFO};
		end else if (reqNumber == `EPS_PN_SENSFMT) begin
			readData = {32'h00000000, SENSOR_FORMAT};
		end else if (reqNumber == `EPS_PN_LIST) begin
			readData = {48'h000000000000, listEntry(reqIndex)}; // [R13]
		end else if (reqNumber == `EPS_PN_STNAME) begin
			if (reqIndex < `EPS_NAME_LEN) begin
				readData = {56'h00000000000000, stationName[reqIndex]}; // [R15]
			end
		end else if (reqNumber == `EPS_PN_STIP) begin
			readData = {32'h00000000, stationIp};
		end else if (reqNumber == `EPS_PN_STMAC) begin
			// six octets in the low bits
			readData = {16'h0000, stationMac};
		end else if (reqNumber == `EPS_PN_STGW) begin
			readData = {32'h00000000, stationGw};
		end else if (reqNumber == `EPS_PN_STMASK) begin
			readData = {32'h00000000, stationMask};
		end else if (reqNumber == `EPS_PN_PRE32) begin
			readData = sext32(preset32View); // [R16]
		end else if (reqNumber == `EPS_PN_PRE64) begin
			readData = preset_q; // [R16]
		end else if (reqNumber == `EPS_PN_OPST32) begin
			if (reqIndex == `EPS_OPST_VER) begin
				readData = {32'h00000000, versionWord}; // [R18]
			end else if (reqIndex == `EPS_OPST_HRS) begin
				readData = {32'h00000000, hoursView};
			end else if (reqIndex == `EPS_OPST_OFS) begin
				readData = sext32(offset32View); // [R7]
			end
		end else if (reqNumber == `EPS_PN_OPST64) begin
			if (reqIndex == `EPS_OPST64_OFS) begin
				readData = offset_q; // [R7] [R18]
			end
		end
	end

	// startup load, one cycle after reset release
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= S_LOAD;
			ready_q <= 1'b0;
		end else begin
			case (state_q)
				S_LOAD: begin
					state_q <= S_RUN;
					ready_q <= 1'b1;
				end
				S_RUN: begin
					state_q <= S_RUN;
					ready_q <= 1'b1;
				end
				default: begin
					state_q <= S_RUN;
					ready_q <= 1'b1;
				end
			endcase
		end
	end

	// hour counting and periodic save
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			hoursUsed_q <= 1'b0;
			hours_q <= 32'h00000000;
			hourTick_q <= 40'h0000000000;
			saveTick_q <= 40'h0000000000;
			nvHoursWr_q <= 1'b0;
			nvHoursData_q <= 32'h00000000;
		end else if (state_q == S_LOAD) begin
			// strap and saved count caught after release, not under reset
			hoursUsed_q <= nvHoursUsed;
			hours_q <= nvHours;
			hourTick_q <= 40'h0000000000;
			saveTick_q <= 40'h0000000000;
			nvHoursWr_q <= 1'b0;
		end else begin
			hourTick_q <= hourDone ? 40'h0000000000 : hourTick_q + 40'h0000000001;
			saveTick_q <= saveDone ? 40'h0000000000 : saveTick_q + 40'h0000000001;
			// saturates so the unused marker is never reached by counting
			if (hourDone && hoursUsed_q && !hoursAtTop) begin
				hours_q <= hours_q + 32'h00000001; // [R19] [R3]
			end
			nvHoursWr_q <= saveDone && hoursUsed_q; // [R4]
			// saved word moves only at the end of each save period, also when hours are unused, so it stands between saves
			if (saveDone) begin
				nvHoursData_q <= hours_q; // [R4]
			end
		end
	end

	// station name loaded by the network stack
	// no reset: the stack rewrites the name after every power-up
	always @(posedge clk) begin
		if (nameWrEn && nameWrIdx < `EPS_NAME_LEN) begin
			stationName[nameWrIdx] <= nameWrByte;
		end
	end

	// parameter access, preset and offset
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rspValid_q <= 1'b0;
			rspError_q <= 1'b0;
			rspData_q <= `EPS_ZERO64;
			offset_q <= `EPS_ZERO64;
			preset_q <= `EPS_ZERO64;
			presetSaved_q <= 1'b0;
			solTol_q <= `EPS_SOLTOL_RST;
			nvParamWr_q <= 1'b0;
			nvOffsetData_q <= `EPS_ZERO64;
			nvPresetData_q <= `EPS_ZERO64;
			nvPresetFlag_q <= 1'b0;
			shiftedPos_q <= `EPS_ZERO64;
		end else if (state_q == S_LOAD) begin
			offset_q <= nvOffset; // [R7]
			presetSaved_q <= nvPresetStored;
			preset_q <= nvPresetStored ? nvPreset : `EPS_ZERO64; // [R17]
			// nothing is loaded yet, so any request here is refused
			rspValid_q <= reqValid;
			rspError_q <= reqValid;
			rspData_q <= `EPS_ZERO64;
			nvParamWr_q <= 1'b0;
		end else begin
			rspValid_q <= reqValid;
			rspError_q <= reqValid && reqBad; // [R20]
			rspData_q <= (reqValid && !reqWrite && !reqBad) ? readData : `EPS_ZERO64;
			nvParamWr_q <= 1'b0;
			shiftedPos_q <= posSum; // [R6]
			if (presetCmd) begin
				offset_q <= newOffset; // [R6] [R9]
				nvParamWr_q <= 1'b1; // [R7]
				nvOffsetData_q <= newOffset;
				nvPresetData_q <= preset_q;
				nvPresetFlag_q <= presetSaved_q;
			end else if (reqValid && reqWrite && !reqBad) begin
				if (reqNumber == `EPS_PN_SOLTOL) begin
					solTol_q <= reqData[15:0]; // [R11]
				end else if (reqNumber == `EPS_PN_PRE32) begin
					preset_q <= sext32(reqData[31:0]); // [R16]
				end else if (reqNumber == `EPS_PN_PRE64) begin
					preset_q <= reqData; // [R16]
				end else if (reqNumber == `EPS_PN_STORE) begin
					// the current offset goes along so the saved pair matches
					presetSaved_q <= 1'b1; // [R12] [R17]
					nvParamWr_q <= 1'b1;
					nvOffsetData_q <= offset_q;
					nvPresetData_q <= preset_q;
					nvPresetFlag_q <= 1'b1;
				end
			end
		end
	end

endmodule // eps_store

// file: verification/eps_store_properties.sv
// port assertions of the parameter store
`include "eps_store_map.vh"
module eps_store_properties #(
	parameter [39:0] SAVE_CYCLES = 40'h10
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// request
	input wire reqValid,
	input wire reqWrite,
	input wire [15:0] reqNumber,
	input wire [7:0] reqIndex,
	input wire presetCmd,
	// response and storage
	input wire rspValid_q,
	input wire rspError_q,
	input wire [63:0] rspData_q,
	input wire nvHoursWr_q,
	input wire nvParamWr_q,
	input wire nvPresetFlag_q,
	input wire ready_q
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire isRo;
	wire take;
	wire saveReq;
	reg [39:0] gapQ;
	reg seenQ;
	assign take = reqValid && ready_q;
	assign saveReq = ready_q && (presetCmd || (reqValid && reqWrite && reqNumber == `EPS_PN_STORE));
	assign isRo = reqNumber == `EPS_PN_TELSEL || reqNumber == `EPS_PN_PROFNUM || reqNumber == `EPS_PN_LIST
		|| (reqNumber >= `EPS_PN_STNAME && reqNumber <= `EPS_PN_STMASK)
		|| reqNumber == `EPS_PN_OPST32 || reqNumber == `EPS_PN_OPST64;
	// cycles since the last hour save; first gap after reset is not judged
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			gapQ <= 40'h0000000000;
			seenQ <= 1'b0;
		end else begin
			gapQ <= nvHoursWr_q ? 40'h0000000001 : gapQ + 40'h0000000001;
			seenQ <= seenQ | nvHoursWr_q;
		end
	end
	property p_answer; reqValid |=> rspValid_q; endproperty
	a_answer: assert property (p_answer) else $error("request not answered");
	property p_quiet; !reqValid |=> !rspValid_q; endproperty
	a_quiet: assert property (p_quiet) else $error("response without request");
	property p_load; reqValid && !ready_q |=> rspError_q; endproperty
	a_load: assert property (p_load) else $error("load cycle request accepted");
	property p_roWrite; take && reqWrite && isRo |=> rspValid_q && rspError_q; endproperty
	a_roWrite: assert property (p_roWrite) else $error("read-only write accepted");
	property p_woRead; take && !reqWrite && reqNumber == `EPS_PN_STORE |=> rspError_q && rspData_q == 64'h0; endproperty
	a_woRead: assert property (p_woRead) else $error("store number read accepted");
	property p_solTol; take && reqNumber == `EPS_PN_SOLTOL |=> !rspError_q; endproperty
	a_solTol: assert property (p_solTol) else $error("tolerance access refused");
	property p_version;
		take && !reqWrite && reqNumber == `EPS_PN_OPST32 && reqIndex == `EPS_OPST_VER
		|=> rspData_q == {32'h0, `EPS_VER_RSVD, `EPS_PROF_MAJOR, `EPS_PROF_MINOR};
	endproperty
	a_version: assert property (p_version) else $error("version word wrong");
	property p_errZero; rspError_q |-> rspData_q == 64'h0; endproperty
	a_errZero: assert property (p_errZero) else $error("data on error");
	property p_store;
		take && reqWrite && reqNumber == `EPS_PN_STORE && !presetCmd |=> nvParamWr_q && nvPresetFlag_q;
	endproperty
	a_store: assert property (p_store) else $error("store not saved");
	property p_saveCause; nvParamWr_q |-> $past(saveReq); endproperty
	a_saveCause: assert property (p_saveCause) else $error("save without cause");
	property p_savePeriod; nvHoursWr_q && seenQ |-> gapQ == SAVE_CYCLES; endproperty
	a_savePeriod: assert property (p_savePeriod) else $error("hour save period wrong");
endmodule // eps_store_properties

// file: verification/eps_ctrl_model.sv
// controller side model: one acyclic parameter access at a time
module eps_ctrl_model (
	// clock
	input wire clk,
	// request
	output logic reqValid,
	output logic reqWrite,
	output logic [15:0] reqNumber,
	output logic [7:0] reqIndex,
	output logic [63:0] reqData,
	// response
	input wire rspValid_q,
	input wire rspError_q,
	input wire [63:0] rspData_q
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		reqValid = 1'b0;
		reqWrite = 1'b0;
		reqNumber = 16'hFFFF;
		reqIndex = 8'hFF;
		reqData = 64'h0;
	end
	// 925 read/write, 971 write only, preset as 32-bit sign-extended or 64-bit
	task automatic access(input logic w, input logic [15:0] n, input logic [7:0] i, input logic [63:0] d,
		output logic e, output logic [63:0] q);
		reqValid = 1'b1;
		reqWrite = w;
		reqNumber = n;
		reqIndex = i;
		reqData = d;
		@(negedge clk);
		e = rspValid_q ? rspError_q : 1'bx;
		q = rspData_q;
		// released lines show no stale value
		reqValid = 1'b0;
		reqWrite = ~w;
		reqNumber = ~n;
		reqIndex = ~i;
		reqData = ~d;
	endtask
endmodule // eps_ctrl_model

// file: verification/test_encoder_parameter_store.sv
// self-checking bench of the parameter store
`include "eps_store_map.vh"
module test_encoder_parameter_store;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	wire reqValid, reqWrite, rspValid_q, rspError_q, nvHoursWr_q, nvParamWr_q, nvPresetFlag_q, ready_q;
	wire [15:0] reqNumber;
	wire [7:0] reqIndex;
	wire [31:0] nvHoursData_q;
	wire [63:0] reqData, rspData_q, nvOffsetData_q, nvPresetData_q, shiftedPos_q;
	logic nvHoursUsed = 1'b1, nvPresetStored = 1'b1, wideRange = 1'b0, compatMode = 1'b0, presetCmd = 1'b0;
	logic [31:0] nvHours = 32'h10, stationIp = 32'hC0A80004, stationGw = 32'hC0A80001, stationMask = 32'hFFFFFF00;
	logic [63:0] nvOffset = 64'h5, nvPreset = 64'h64, scaledPos = 64'h3E8;
	logic nameWrEn = 1'b0;
	logic [7:0] nameWrIdx = 8'h00, nameWrByte = 8'h41;
	logic [47:0] stationMac = 48'h020000000001;
	logic e;
	logic [63:0] q;
	logic [31:0] h;
	logic [15:0] roList [14] = '{`EPS_PN_TELSEL, `EPS_PN_DEVID, `EPS_PN_PROFNUM, `EPS_PN_ACCID, `EPS_PN_OBJID,
		`EPS_PN_SENSFMT, `EPS_PN_LIST, `EPS_PN_STNAME, `EPS_PN_STIP, `EPS_PN_STMAC, `EPS_PN_STGW, `EPS_PN_STMASK,
		`EPS_PN_OPST32, `EPS_PN_OPST64};
	int numErrors = 0, testsRun = 0, cycles = 0;
	// short hour and save periods keep the run brief
	eps_store #(.HOUR_CYCLES(40'h28), .SAVE_CYCLES(40'h10)) uut (.clk, .rst, .reqValid, .reqWrite, .reqNumber,
		.reqIndex, .reqData, .rspValid_q, .rspError_q, .rspData_q, .nvHoursUsed, .nvHours, .nvOffset,
		.nvPresetStored, .nvPreset, .nvHoursWr_q, .nvHoursData_q, .nvParamWr_q, .nvOffsetData_q,
		.nvPresetData_q, .nvPresetFlag_q, .wideRange, .compatMode, .presetCmd, .scaledPos, .shiftedPos_q,
		.ready_q, .nameWrEn, .nameWrIdx, .nameWrByte, .stationIp, .stationMac, .stationGw, .stationMask);
	eps_ctrl_model ctrl (.clk, .reqValid, .reqWrite, .reqNumber, .reqIndex, .reqData, .rspValid_q, .rspError_q,
		.rspData_q);
	always #12.5 clk = ~clk;
	task conclude;
		if (numErrors == 0 && testsRun > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			numErrors++;
			conclude();
		end
	end
	task chkData(input logic [63:0] got, input logic [63:0] exp);
		testsRun++;
		if (got !== exp) begin
			numErrors++;
			$display("FAIL %0t data %h expected %h", $time, got, exp);
		end
	endtask
	task chkFlag(input logic got, input logic exp);
		testsRun++;
		if (got !== exp) begin
			numErrors++;
			$display("FAIL %0t flag %b expected %b", $time, got, exp);
		end
	endtask
	task acc(input logic w, input logic [15:0] n, input logic [7:0] i, input logic [63:0] d, input logic ee,
		input logic [63:0] eq);
		ctrl.access(w, n, i, d, e, q);
		chkFlag(e, ee);
		chkData(q, eq);
		@(negedge clk);
	endtask
	// preset: saved offset next cycle, shifted position one cycle later
	task preset(input logic [63:0] pv, input logic [63:0] ofs);
		presetCmd = 1'b1;
		@(negedge clk);
		presetCmd = 1'b0;
		chkFlag(nvParamWr_q, 1'b1);
		chkData(nvOffsetData_q, ofs);
		@(negedge clk);
		chkData(shiftedPos_q, pv);
		@(negedge clk);
	endtask
	initial begin
		repeat (12) @(negedge clk);
		rst = 1'b0;
		repeat (2) @(negedge clk);
		acc(1'b0, `EPS_PN_PRE32, 8'h0, 64'h0, 1'b0, 64'h64);
		acc(1'b0, `EPS_PN_OPST32, `EPS_OPST_VER, 64'h0, 1'b0, 64'h401);
		compatMode = 1'b1;
		acc(1'b0, `EPS_PN_OPST32, `EPS_OPST_VER, 64'h0, 1'b0, 64'h401);
		acc(1'b0, `EPS_PN_OPST64, `EPS_OPST64_OFS, 64'h0, 1'b0, 64'h5);
		acc(1'b0, `EPS_PN_LIST, 8'h00, 64'h0, 1'b0, 64'h039A);
		acc(1'b0, `EPS_PN_LIST, 8'h11, 64'h0, 1'b0, 64'hFDEB);
		acc(1'b0, `EPS_PN_LIST, 8'h12, 64'h0, 1'b0, 64'h0);
		acc(1'b0, `EPS_PN_STIP, 8'h0, 64'h0, 1'b0, {32'h0, stationIp});
		acc(1'b0, `EPS_PN_STMASK, 8'h0, 64'h0, 1'b0, {32'h0, stationMask});
		foreach (roList[k]) acc(1'b1, roList[k], 8'h0, 64'h1, 1'b1, 64'h0);
		acc(1'b0, `EPS_PN_OPST32, `EPS_OPST_OFS, 64'h0, 1'b0, 64'h5);
		acc(1'b0, `EPS_PN_STORE, 8'h0, 64'h0, 1'b1, 64'h0);
		acc(1'b0, 16'h0001, 8'h0, 64'h0, 1'b1, 64'h0);
		acc(1'b0, `EPS_PN_SOLTOL, 8'h0, 64'h0, 1'b0, {48'h0, `EPS_SOLTOL_RST});
		acc(1'b1, `EPS_PN_SOLTOL, 8'h0, 64'h7, 1'b0, 64'h0);
		acc(1'b0, `EPS_PN_SOLTOL, 8'h0, 64'h0, 1'b0, 64'h7);
		nameWrEn = 1'b1;
		@(negedge clk);
		nameWrEn = 1'b0;
		acc(1'b0, `EPS_PN_STNAME, 8'h00, 64'h0, 1'b0, 64'h41);
		acc(1'b0, `EPS_PN_STMAC, 8'h0, 64'h0, 1'b0, {16'h0, stationMac});
		acc(1'b0, `EPS_PN_STGW, 8'h0, 64'h0, 1'b0, {32'h0, stationGw});
		// two reads one hour period apart differ by one
		ctrl.access(1'b0, `EPS_PN_OPST32, `EPS_OPST_HRS, 64'h0, e, q);
		chkFlag(e, 1'b0);
		h = q[31:0] + 32'h1;
		repeat (39) @(negedge clk);
		acc(1'b0, `EPS_PN_OPST32, `EPS_OPST_HRS, 64'h0, 1'b0, {32'h0, h});
		// the next periodic save carries the count of that moment
		for (int k = 0; k < 17 && !nvHoursWr_q; k++) @(negedge clk);
		chkFlag(nvHoursWr_q, 1'b1);
		chkFlag(nvHoursData_q == h || nvHoursData_q == h + 32'h1, 1'b1);
		acc(1'b1, `EPS_PN_PRE32, 8'h0, 64'h7D0, 1'b0, 64'h0);
		preset(64'h7D0, 64'h3E8);
		acc(1'b0, `EPS_PN_OPST32, `EPS_OPST_OFS, 64'h0, 1'b0, 64'h3E8);
		acc(1'b1, `EPS_PN_PRE32, 8'h0, 64'hFFFFFFFFFFFFFFFF, 1'b0, 64'h0);
		preset(64'hFFFFFFFFFFFFFFFF, 64'hFFFFFFFFFFFFFC17);
		wideRange = 1'b1;
		acc(1'b1, `EPS_PN_PRE64, 8'h0, 64'h100000000, 1'b0, 64'h0);
		preset(64'h100000000, 64'hFFFFFC18);
		acc(1'b0, `EPS_PN_OPST32, `EPS_OPST_OFS, 64'h0, 1'b0, 64'h0);
		ctrl.access(1'b1, `EPS_PN_STORE, 8'h0, 64'h0, e, q);
		chkFlag(e, 1'b0);
		chkFlag(nvParamWr_q, 1'b1);
		chkFlag(nvPresetFlag_q, 1'b1);
		chkData(nvPresetData_q, 64'h100000000);
		@(negedge clk);
		// second power-up: hours unused, no stored preset
		nvHoursUsed = 1'b0;
		nvPresetStored = 1'b0;
		rst = 1'b1;
		repeat (12) @(negedge clk);
		rst = 1'b0;
		acc(1'b0, `EPS_PN_SOLTOL, 8'h0, 64'h0, 1'b1, 64'h0);
		acc(1'b0, `EPS_PN_OPST32, `EPS_OPST_HRS, 64'h0, 1'b0, 64'h00000000FFFFFFFF);
		acc(1'b0, `EPS_PN_OPST64, `EPS_OPST64_OFS, 64'h0, 1'b0, 64'h5);
		acc(1'b0, `EPS_PN_PRE64, 8'h0, 64'h0, 1'b0, 64'h0);
		conclude();
	end
endmodule // test_encoder_parameter_store
bind eps_store eps_store_properties #(.SAVE_CYCLES(SAVE_CYCLES)) props (.clk, .rst, .reqValid, .reqWrite,
	.reqNumber, .reqIndex, .presetCmd, .rspValid_q, .rspError_q, .rspData_q, .nvHoursWr_q, .nvParamWr_q,
	.nvPresetFlag_q, .ready_q);
